// ===== clk_divider.sv
// one peripheral clock divider, integer or fractional, ticking on the root clock
`timescale 1ns/100ps
module clk_divider #(
   parameter int DIV_W = 16,
   parameter int FRAC_W = 5,
   parameter bit FRACTIONAL = 1'b0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic clr,
   input wire logic root_tick,
   input wire logic enable,
   input wire logic [DIV_W-1:0] div_int,
   input wire logic [FRAC_W-1:0] div_frac,
   output logic tick_q
);
   logic [DIV_W-1:0] cnt_q;
   logic [FRAC_W-1:0] acc_q;
   logic [FRAC_W:0] acc_sum;
   logic extra;

   // --------------------------------------------------------------------
   // fractional stretch
   // --------------------------------------------------------------------
   // the fraction stretches div_frac periods in every 2**FRAC_W by a root tick
   always_comb begin
      acc_sum = {1'b0, acc_q} + {1'b0, div_frac};
      extra = FRACTIONAL && acc_sum[FRAC_W];
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_q <= '0;
      end else if (clr || !enable) begin
         acc_q <= '0;
      end else if (FRACTIONAL && root_tick && cnt_q == '0) begin
         acc_q <= acc_sum[FRAC_W-1:0];
      end
   end

   // --------------------------------------------------------------------
   // period counter
   // --------------------------------------------------------------------
   // period is div_int + 1 root ticks, one more when stretched, so the output stays root-synchronous
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
         tick_q <= 1'b0;
      end else if (clr || !enable) begin
         cnt_q <= '0;
         tick_q <= 1'b0;
      end else begin
         tick_q <= root_tick && cnt_q == '0;
         if (root_tick) begin
            if (cnt_q == '0) begin
               cnt_q <= div_int + DIV_W'(extra);
            end else begin
               cnt_q <= cnt_q - 1'b1;
            end
         end
      end
   end
endmodule

// ===== clk_rst_pwr_ctrl.sv
// clock, reset and power control: shared constants and the top module
package clk_rst_pwr_pkg;
   localparam logic [5:0] MAIN_OSC_RESET_MHZ = 6'h18;
   localparam logic [5:0] MAIN_OSC_MAX_MHZ = 6'h30;
   localparam logic [5:0] MAIN_OSC_STEP_MHZ = 6'h04;
   localparam int NUM_DIVIDERS = 8;
   localparam int NUM_FRAC_DIVIDERS = 2;
   localparam int DIV_WIDTH = 16;
   localparam int FRAC_WIDTH = 5;
   localparam int CLK_KHZ = 20000;
   localparam int WAKE_TIME_US = 35;
   // longest time, rounded down
   localparam int WAKE_CYCLES = WAKE_TIME_US * CLK_KHZ / 1000;
   localparam logic [4:0] RESET_HOLD_CYCLES = 5'h10;
   localparam logic [15:0] WDT_CNT_RESET = 16'hffff;
   localparam int CAUSE_WDT = 0;
   localparam int CAUSE_SOFT = 1;
   localparam int CAUSE_EXT = 2;
   localparam int CAUSE_BROWNOUT = 3;
   localparam logic [3:0] CAUSE_RESET = 4'h0;
   // sync bits: 0 low-freq osc, 1 crystal, 2 ext clock, 3 reset pin, 4 supply ok, 6:5 comparators
   localparam logic [6:0] SYNC_RESET = 7'h08;
   typedef enum logic [1:0] {SRC_MAIN, SRC_LF, SRC_XTAL, SRC_EXT} clk_src_t;
   typedef enum logic [1:0] {PWR_ACTIVE, PWR_SLEEP, PWR_DEEP, PWR_WAKING} pwr_state_t;
endpackage

`timescale 1ns/100ps
module clk_rst_pwr_ctrl (
   input wire logic clk,
   input wire logic rst,
   input wire logic main_osc_trim_wr,
   input wire logic [5:0] main_osc_trim_mhz,
   input wire logic [1:0] src_sel,
   input wire logic low_freq_rc_oscillator,
   input wire logic crystal_32k_oscillator,
   input wire logic ext_clk_in,
   input wire logic [7:0] div_enable,
   input wire logic [127:0] div_int,
   input wire logic [9:0] div_frac,
   input wire logic external_reset_pin_n,
   input wire logic soft_reset_req,
   input wire logic supply_ok,
   input wire logic wdt_enable,
   input wire logic [15:0] wdt_timeout,
   input wire logic wdt_kick,
   input wire logic [3:0] cause_clear,
   input wire logic sleep_req,
   input wire logic deep_sleep_req,
   input wire logic wake_event,
   input wire logic [7:0] irq_pending,
   input wire logic [7:0] irq_enable,
   input wire logic [1:0] low_power_comparator,
   input wire logic comp_async_mode,
   input wire logic debug_disable,
   input wire logic device_erased,
   input wire logic protection_cleared,
   input wire logic fw_debug_enable,
   input wire logic max_security,
   output logic [5:0] main_rc_oscillator_mhz_q,
   output clk_rst_pwr_pkg::clk_src_t root_src_q,
   output logic high_freq_root_clock_q,
   output logic lf_clk_tick_q,
   output logic [7:0] div_tick_q,
   output logic cpu_clk_en_q,
   output logic hf_clk_en_q,
   output clk_rst_pwr_pkg::pwr_state_t power_mode_q,
   output logic cpu_wakeup_q,
   output logic sys_reset_q,
   output logic [3:0] reset_cause_q,
   output logic debug_port_en_q,
   output logic prog_port_en_q,
   output logic test_port_en_q
);
   logic [6:0] sync1_q, sync2_q, prev_q;
   logic [3:0] src_tick, reset_src;
   logic [15:0] wdt_cnt_q;
   logic [4:0] hold_q;
   logic [9:0] wake_cnt_q;
   logic wdt_expire, irq_hit, comp_wake, deep_wake, debug_en_q, secure_q;
   clk_rst_pwr_pkg::pwr_state_t pwr_d;

   // ------------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------------
   // two flops before use
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_q <= clk_rst_pwr_pkg::SYNC_RESET;
         sync2_q <= clk_rst_pwr_pkg::SYNC_RESET;
         prev_q <= clk_rst_pwr_pkg::SYNC_RESET;
      end else begin
         sync1_q <= {low_power_comparator, supply_ok, external_reset_pin_n,
                     ext_clk_in, crystal_32k_oscillator, low_freq_rc_oscillator};
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   always_comb begin
      src_tick[clk_rst_pwr_pkg::SRC_MAIN] = 1'b1;
      src_tick[clk_rst_pwr_pkg::SRC_LF] = sync2_q[0] && !prev_q[0];
      src_tick[clk_rst_pwr_pkg::SRC_XTAL] = sync2_q[1] && !prev_q[1];
      src_tick[clk_rst_pwr_pkg::SRC_EXT] = sync2_q[2] && !prev_q[2];
   end

   // ------------------------------------------------------------------
   // main oscillator trim
   // ------------------------------------------------------------------
   // out-of-range or off-step writes are ignored
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         main_rc_oscillator_mhz_q <= clk_rst_pwr_pkg::MAIN_OSC_RESET_MHZ;
      end else if (sys_reset_q) begin
         main_rc_oscillator_mhz_q <= clk_rst_pwr_pkg::MAIN_OSC_RESET_MHZ;
      end else if (main_osc_trim_wr && main_osc_trim_mhz >= clk_rst_pwr_pkg::MAIN_OSC_RESET_MHZ
                   && main_osc_trim_mhz <= clk_rst_pwr_pkg::MAIN_OSC_MAX_MHZ
                   && main_osc_trim_mhz[1:0] == 2'b00) begin
         main_rc_oscillator_mhz_q <= main_osc_trim_mhz;
      end
   end

   // ------------------------------------------------------------------
   // root clock and source switch
   // ------------------------------------------------------------------
   // swap on the old source's tick, so no period is cut short
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         root_src_q <= clk_rst_pwr_pkg::SRC_MAIN;
      end else if (sys_reset_q) begin
         root_src_q <= clk_rst_pwr_pkg::SRC_MAIN;
      end else if (src_sel != root_src_q && src_tick[root_src_q]) begin
         root_src_q <= clk_rst_pwr_pkg::clk_src_t'(src_sel);
      end
   end

   // root stops while deep sleep holds the enable low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         high_freq_root_clock_q <= 1'b0;
         lf_clk_tick_q <= 1'b0;
      end else begin
         high_freq_root_clock_q <= hf_clk_en_q && src_tick[root_src_q];
         // low-freq tick keeps running in deep sleep
         lf_clk_tick_q <= src_tick[clk_rst_pwr_pkg::SRC_LF];
      end
   end

   // ------------------------------------------------------------------
   // peripheral dividers
   // ------------------------------------------------------------------
   // last two dividers fractional
   for (genvar i = 0; i < clk_rst_pwr_pkg::NUM_DIVIDERS; i++) begin : g_div
      localparam bit IS_FRAC = i >= clk_rst_pwr_pkg::NUM_DIVIDERS - clk_rst_pwr_pkg::NUM_FRAC_DIVIDERS;
      logic [clk_rst_pwr_pkg::FRAC_WIDTH-1:0] frac;
      if (IS_FRAC) begin : g_frac
         assign frac = div_frac[(i - 6) * 5 +: 5];
      end else begin : g_int
         assign frac = '0;
      end
      clk_divider #(
         .DIV_W(clk_rst_pwr_pkg::DIV_WIDTH),
         .FRAC_W(clk_rst_pwr_pkg::FRAC_WIDTH),
         .FRACTIONAL(IS_FRAC)
      ) u_div (
         .clk(clk),
         .rst(rst),
         .clr(sys_reset_q),
         .root_tick(high_freq_root_clock_q),
         .enable(div_enable[i]),
         .div_int(div_int[i * 16 +: 16]),
         .div_frac(frac),
         .tick_q(div_tick_q[i])
      );
   end

   // ------------------------------------------------------------------
   // watchdog
   // ------------------------------------------------------------------
   // kick reloads full timeout; counts low-freq ticks only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wdt_cnt_q <= clk_rst_pwr_pkg::WDT_CNT_RESET;
      end else if (sys_reset_q || wdt_kick || !wdt_enable) begin
         wdt_cnt_q <= wdt_timeout;
      end else if (src_tick[clk_rst_pwr_pkg::SRC_LF] && wdt_cnt_q != '0) begin
         wdt_cnt_q <= wdt_cnt_q - 1'b1;
      end
   end
   assign wdt_expire = wdt_enable && wdt_cnt_q == '0 && !sys_reset_q && !wdt_kick;

   // ------------------------------------------------------------------
   // reset generation and cause
   // ------------------------------------------------------------------
   // brownout is a falling supply-good edge
   always_comb begin
      reset_src = '0;
      reset_src[clk_rst_pwr_pkg::CAUSE_WDT] = wdt_expire;
      reset_src[clk_rst_pwr_pkg::CAUSE_SOFT] = soft_reset_req;
      reset_src[clk_rst_pwr_pkg::CAUSE_EXT] = !sync2_q[3];
      reset_src[clk_rst_pwr_pkg::CAUSE_BROWNOUT] = prev_q[4] && !sync2_q[4];
   end

   // any source stretches a reset of fixed length
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_q <= clk_rst_pwr_pkg::RESET_HOLD_CYCLES;
         sys_reset_q <= 1'b1;
      end else if (reset_src != '0) begin
         hold_q <= clk_rst_pwr_pkg::RESET_HOLD_CYCLES;
         sys_reset_q <= 1'b1;
      end else if (hold_q != '0) begin
         hold_q <= hold_q - 1'b1;
         sys_reset_q <= 1'b1;
      end else begin
         sys_reset_q <= 1'b0;
      end
   end

   // power-on or cause_clear clears it; set wins over clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reset_cause_q <= clk_rst_pwr_pkg::CAUSE_RESET;
      end else begin
         reset_cause_q <= (reset_cause_q & ~cause_clear) | reset_src;
      end
   end

   // ------------------------------------------------------------------
   // power modes
   // ------------------------------------------------------------------
   // wake unit: any enabled pending interrupt
   assign irq_hit = (irq_pending & irq_enable) != '0;
   // raw edge only in asynchronous mode
   assign comp_wake = comp_async_mode ? (low_power_comparator != sync2_q[6:5])
                                      : (sync2_q[6:5] != prev_q[6:5]);
   assign deep_wake = irq_hit || comp_wake;

   always_comb begin
      pwr_d = power_mode_q;
      unique case (power_mode_q)
         clk_rst_pwr_pkg::PWR_ACTIVE: begin
            // entry held off until supply good
            if (deep_sleep_req && sync2_q[4]) begin
               pwr_d = clk_rst_pwr_pkg::PWR_DEEP;
            end else if (sleep_req && sync2_q[4]) begin
               pwr_d = clk_rst_pwr_pkg::PWR_SLEEP;
            end
         end
         clk_rst_pwr_pkg::PWR_SLEEP: begin
            if (wake_event || irq_hit) begin
               pwr_d = clk_rst_pwr_pkg::PWR_ACTIVE;
            end
         end
         clk_rst_pwr_pkg::PWR_DEEP: begin
            if (deep_wake) begin
               pwr_d = clk_rst_pwr_pkg::PWR_WAKING;
            end
         end
         clk_rst_pwr_pkg::PWR_WAKING: begin
            if (wake_cnt_q == '0) begin
               pwr_d = clk_rst_pwr_pkg::PWR_ACTIVE;
            end
         end
      endcase
      if (sys_reset_q) begin
         pwr_d = clk_rst_pwr_pkg::PWR_ACTIVE;
      end
   end

   // wake counter bounded by the 35 us figure
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wake_cnt_q <= '0;
      end else if (pwr_d == clk_rst_pwr_pkg::PWR_WAKING && power_mode_q == clk_rst_pwr_pkg::PWR_DEEP) begin
         wake_cnt_q <= 10'(clk_rst_pwr_pkg::WAKE_CYCLES - 2);
      end else if (wake_cnt_q != '0) begin
         wake_cnt_q <= wake_cnt_q - 1'b1;
      end
   end

   // clock enables follow the next mode
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         power_mode_q <= clk_rst_pwr_pkg::PWR_ACTIVE;
         cpu_clk_en_q <= 1'b1;
         hf_clk_en_q <= 1'b1;
         cpu_wakeup_q <= 1'b0;
      end else begin
         power_mode_q <= pwr_d;
         cpu_clk_en_q <= pwr_d == clk_rst_pwr_pkg::PWR_ACTIVE;
         hf_clk_en_q <= pwr_d != clk_rst_pwr_pkg::PWR_DEEP;
         cpu_wakeup_q <= pwr_d == clk_rst_pwr_pkg::PWR_ACTIVE && power_mode_q != clk_rst_pwr_pkg::PWR_ACTIVE
                         && !sys_reset_q;
      end
   end

   // ------------------------------------------------------------------
   // debug and security gating
   // ------------------------------------------------------------------
   // internal resets do not re-enable debug
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         debug_en_q <= 1'b1;
      end else if (debug_disable) begin
         debug_en_q <= 1'b0;
      end else if (device_erased && protection_cleared && fw_debug_enable) begin
         debug_en_q <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         secure_q <= 1'b0;
         debug_port_en_q <= 1'b0;
         prog_port_en_q <= 1'b0;
         test_port_en_q <= 1'b0;
      end else begin
         secure_q <= secure_q || max_security;
         debug_port_en_q <= debug_en_q && !secure_q && !max_security;
         prog_port_en_q <= !secure_q && !max_security;
         test_port_en_q <= !secure_q && !max_security;
      end
   end

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   localparam int wake_bound = clk_rst_pwr_pkg::WAKE_CYCLES;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   a_trim_in_range: assert property (
      main_rc_oscillator_mhz_q >= 6'h18 && main_rc_oscillator_mhz_q <= 6'h30
      && main_rc_oscillator_mhz_q[1:0] == 2'b00)
      else $error("main oscillator trim out of range");
   a_src_on_tick: assert property (
      $changed(root_src_q) && !$past(sys_reset_q) |-> $past(src_tick[root_src_q]))
      else $error("root source swapped mid-period");
   a_wdt_fires: assert property (
      wdt_enable && wdt_cnt_q == '0 && !sys_reset_q && !wdt_kick |=> sys_reset_q
      && reset_cause_q[0])
      else $error("watchdog timeout gave no reset");
   a_cause_sticky: assert property (
      reset_cause_q[0] && !cause_clear[0] |=> reset_cause_q[0])
      else $error("reset cause lost");
   a_set_beats_clear: assert property (
      (reset_src & cause_clear) != '0 |=> (reset_cause_q & $past(reset_src)) == $past(reset_src))
      else $error("new cause lost to clear");
   a_sleep_gates_cpu: assert property (
      power_mode_q == clk_rst_pwr_pkg::PWR_SLEEP |-> !cpu_clk_en_q && hf_clk_en_q)
      else $error("sleep clock gating wrong");
   a_deep_stops_root: assert property (
      power_mode_q == clk_rst_pwr_pkg::PWR_DEEP |=> !high_freq_root_clock_q)
      else $error("root ticks in deep sleep");
   a_wake_time: assert property (
      power_mode_q == clk_rst_pwr_pkg::PWR_DEEP && pwr_d == clk_rst_pwr_pkg::PWR_WAKING
      |-> ##[1:wake_bound] cpu_clk_en_q)
      else $error("deep sleep wake too slow");
   a_secure_blocks: assert property (
      secure_q |=> !debug_port_en_q && !prog_port_en_q && !test_port_en_q)
      else $error("port open under security");
   a_debug_stays_off: assert property (
      !debug_en_q && !(device_erased && protection_cleared && fw_debug_enable) |=> !debug_en_q)
      else $error("debug re-enabled without erase");
endmodule

// ===== clk_pin_model.sv
// far-side model: oscillator pins, external clock and the reset pin driver
`timescale 1ns/100ps
module clk_pin_model #(
   parameter real LF_HALF_NS = 12500.0,
   parameter real XTAL_HALF_NS = 15258.8,
   parameter real EXT_HALF_NS = 500.0
) (
   input wire logic drive_reset_low,
   output logic low_freq_rc_oscillator,
   output logic crystal_32k_oscillator,
   output logic ext_clk_in,
   output logic external_reset_pin_n
);
   // ----------------------------------------
   // free-running oscillators
   // ----------------------------------------
   // nominal 40 kHz, phase unrelated to clk
   initial begin
      low_freq_rc_oscillator = 1'b0;
      #7;
      forever #(LF_HALF_NS) low_freq_rc_oscillator = ~low_freq_rc_oscillator;
   end
   initial begin
      crystal_32k_oscillator = 1'b0;
      ext_clk_in = 1'b0;
      fork
         forever #(XTAL_HALF_NS) crystal_32k_oscillator = ~crystal_32k_oscillator;
         forever #(EXT_HALF_NS) ext_clk_in = ~ext_clk_in;
      join
   end
   // ----------------------------------------
   // reset pin
   // ----------------------------------------
   // driven low only on request, pull-up otherwise
   assign external_reset_pin_n = drive_reset_low ? 1'b0 : 1'b1;
endmodule

// ===== test_clock_reset_power_control.sv
// self-checking bench for the clock, reset and power controller
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module test_clock_reset_power_control;
   logic clk, rst, main_osc_trim_wr, soft_reset_req, supply_ok, wdt_enable, wdt_kick, sleep_req, deep_sleep_req;
   logic wake_event, comp_async_mode, debug_disable, device_erased, protection_cleared, fw_debug_enable, max_security;
   logic pin_low;
   logic [5:0] main_osc_trim_mhz, main_rc_oscillator_mhz_q;
   logic [1:0] src_sel, low_power_comparator;
   logic [7:0] div_enable, irq_pending, irq_enable, div_tick_q;
   logic [127:0] div_int;
   logic [9:0] div_frac;
   logic [15:0] wdt_timeout;
   logic [3:0] cause_clear, reset_cause_q, exp_cause;
   wire low_freq_rc_oscillator, crystal_32k_oscillator, ext_clk_in, external_reset_pin_n;
   clk_rst_pwr_pkg::clk_src_t root_src_q;
   clk_rst_pwr_pkg::pwr_state_t power_mode_q;
   logic high_freq_root_clock_q, lf_clk_tick_q, cpu_clk_en_q, hf_clk_en_q, cpu_wakeup_q, sys_reset_q;
   logic debug_port_en_q, prog_port_en_q, test_port_en_q;
   logic [5:0] exp_mhz;
   int fail_count, cmp_count, cycles, c, n, k, fr, seed_v;

   clk_rst_pwr_ctrl u_dut (.clk, .rst, .main_osc_trim_wr, .main_osc_trim_mhz, .src_sel, .low_freq_rc_oscillator,
      .crystal_32k_oscillator, .ext_clk_in, .div_enable, .div_int, .div_frac, .external_reset_pin_n, .soft_reset_req,
      .supply_ok, .wdt_enable, .wdt_timeout, .wdt_kick, .cause_clear, .sleep_req, .deep_sleep_req, .wake_event,
      .irq_pending, .irq_enable, .low_power_comparator, .comp_async_mode, .debug_disable, .device_erased,
      .protection_cleared, .fw_debug_enable, .max_security, .main_rc_oscillator_mhz_q, .root_src_q,
      .high_freq_root_clock_q, .lf_clk_tick_q, .div_tick_q, .cpu_clk_en_q, .hf_clk_en_q, .power_mode_q,
      .cpu_wakeup_q, .sys_reset_q, .reset_cause_q, .debug_port_en_q, .prog_port_en_q, .test_port_en_q);
   clk_pin_model u_pins (.drive_reset_low(pin_low), .low_freq_rc_oscillator, .crystal_32k_oscillator,
      .ext_clk_in, .external_reset_pin_n);

   // ----------------------------------------
   // clock, timeout, helpers
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // a hang counts as a failure
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         fail_count++;
         complete_run();
      end
   end
   task automatic step(input int m);
      repeat (m) @(posedge clk);
      #2;
   endtask
   task automatic wait_idle();
      c = 0;
      while (sys_reset_q !== 1'b0 && c < 200) begin step(1); c++; end
   endtask
   task automatic wait_mode(input clk_rst_pwr_pkg::pwr_state_t m, input int lim);
      c = 0;
      while (power_mode_q !== m && c < lim) begin step(1); c++; end
   endtask
   task automatic div_period(input int i, input int p, input int f);
      div_int = 128'(p) << (16 * i);
      div_frac = {5'(f), 5'(f)};
      div_enable = 8'h01 << i;
      c = 0;
      while (div_tick_q[i] !== 1'b1 && c < 60) begin step(1); c++; end
      // 32 periods: a fractional divider adds exactly f root ticks
      c = 0;
      repeat (32) begin
         step(1);
         c++;
         while (div_tick_q[i] !== 1'b1 && c < 2000) begin step(1); c++; end
      end
      `CHK(c, 32 * (p + 1) + (i >= 6 ? f : 0))
      div_enable = 8'h00;
      step(1);
   endtask
   task automatic complete_run();
      if (fail_count == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {rst, main_osc_trim_wr, soft_reset_req, wdt_enable, wdt_kick, sleep_req, deep_sleep_req, wake_event} = 8'h80;
      {comp_async_mode, debug_disable, device_erased, protection_cleared, fw_debug_enable, max_security} = 6'h00;
      {pin_low, supply_ok, main_osc_trim_mhz, src_sel, low_power_comparator, div_enable} = 20'h40000;
      {irq_pending, irq_enable, div_int, div_frac, wdt_timeout, cause_clear} = '0;
      seed_v = $urandom(40301);
      exp_cause = 4'h0;
      exp_mhz = 6'h18;
      repeat (5) @(posedge clk);
      #2 rst = 1'b0;
      wait_idle();
      `CHK(main_rc_oscillator_mhz_q, exp_mhz)
      `CHK({reset_cause_q, power_mode_q, cpu_clk_en_q, hf_clk_en_q}, 8'h03)
      `CHK({debug_port_en_q, prog_port_en_q, test_port_en_q}, 3'h7)
      // every trim code, only 24..48 in steps of 4 may land
      main_osc_trim_wr = 1'b1;
      for (k = 0; k < 64; k++) begin
         main_osc_trim_mhz = 6'(k);
         if (k >= 24 && k <= 48 && k % 4 == 0) exp_mhz = 6'(k);
         step(1);
         `CHK(main_rc_oscillator_mhz_q, exp_mhz)
      end
      main_osc_trim_wr = 1'b0;
      n = $urandom_range(1, 9);
      fr = $urandom_range(1, 31);
      div_period($urandom_range(0, 5), n, fr);
      div_period(7, n, fr);
      // low-freq root: ticks one cycle wide, two per 1000 cycles
      src_sel = 2'h1;
      wait_mode(clk_rst_pwr_pkg::PWR_ACTIVE, 1);
      c = 0;
      while (root_src_q !== clk_rst_pwr_pkg::SRC_LF && c < 1200) begin step(1); c++; end
      n = 0;
      k = 0;
      repeat (1000) begin
         step(1);
         n += int'(high_freq_root_clock_q === 1'b1);
         k += int'(lf_clk_tick_q === 1'b1);
      end
      `CHK(n, 2)
      `CHK(k, 2)
      src_sel = 2'h0;
      step(1200);
      `CHK(root_src_q, clk_rst_pwr_pkg::SRC_MAIN)
      // external clock: one tick per 20 cycles; then crystal, then main again
      src_sel = 2'h3;
      step(2);
      n = 0;
      repeat (200) begin step(1); n += int'(high_freq_root_clock_q === 1'b1); end
      `CHK(n, 10)
      src_sel = 2'h2;
      step(1300);
      `CHK(root_src_q, clk_rst_pwr_pkg::SRC_XTAL)
      src_sel = 2'h0;
      step(1300);
      `CHK(root_src_q, clk_rst_pwr_pkg::SRC_MAIN)
      // watchdog: kicked in time, then left to expire
      wdt_timeout = 16'h0003;
      step(2);
      wdt_enable = 1'b1;
      repeat (10) begin step(200); wdt_kick = 1'b1; step(1); wdt_kick = 1'b0; end
      `CHK(sys_reset_q, 1'b0)
      c = 0;
      while (sys_reset_q !== 1'b1 && c < 2500) begin step(1); c++; end
      wdt_enable = 1'b0;
      exp_cause[0] = 1'b1;
      `CHK(reset_cause_q, exp_cause)
      wait_idle();
      soft_reset_req = 1'b1;
      step(1);
      soft_reset_req = 1'b0;
      exp_cause[1] = 1'b1;
      wait_idle();
      `CHK(c, int'(clk_rst_pwr_pkg::RESET_HOLD_CYCLES) + 1)
      pin_low = 1'b1;
      step(5);
      pin_low = 1'b0;
      wait_idle();
      supply_ok = 1'b0;
      step(4);
      supply_ok = 1'b1;
      wait_idle();
      exp_cause[3:2] = 2'h3;
      `CHK(reset_cause_q, exp_cause)
      cause_clear = 4'hf;
      step(1);
      cause_clear = 4'h0;
      `CHK(reset_cause_q, 4'h0)
      // a new cause in the clearing cycle wins
      step(1);
      {soft_reset_req, cause_clear} = 5'h1f;
      step(1);
      {soft_reset_req, cause_clear} = 5'h00;
      `CHK(reset_cause_q, 4'h2)
      wait_idle();
      // sleep and wake
      sleep_req = 1'b1;
      step(1);
      sleep_req = 1'b0;
      `CHK({power_mode_q, cpu_clk_en_q, hf_clk_en_q}, 4'h5)
      wake_event = 1'b1;
      step(1);
      wake_event = 1'b0;
      `CHK({power_mode_q, cpu_wakeup_q}, 3'h1)
      deep_sleep_req = 1'b1;
      step(1);
      deep_sleep_req = 1'b0;
      `CHK({power_mode_q, hf_clk_en_q}, 3'h4)
      irq_pending = 8'($urandom_range(1, 255));
      step(10);
      `CHK(power_mode_q, clk_rst_pwr_pkg::PWR_DEEP)
      irq_enable = irq_pending;
      wait_mode(clk_rst_pwr_pkg::PWR_ACTIVE, 800);
      `CHK({c <= clk_rst_pwr_pkg::WAKE_CYCLES, cpu_wakeup_q}, 2'h3)
      irq_pending = 8'h00;
      deep_sleep_req = 1'b1;
      comp_async_mode = 1'b1;
      step(1);
      deep_sleep_req = 1'b0;
      low_power_comparator = 2'h1;
      step(1);
      `CHK(power_mode_q, clk_rst_pwr_pkg::PWR_WAKING)
      wait_mode(clk_rst_pwr_pkg::PWR_ACTIVE, 800);
      `CHK(power_mode_q, clk_rst_pwr_pkg::PWR_ACTIVE)
      // synchronised mode: the change passes both sync flops first
      comp_async_mode = 1'b0;
      deep_sleep_req = 1'b1;
      step(1);
      deep_sleep_req = 1'b0;
      low_power_comparator = 2'h0;
      step(2);
      `CHK(power_mode_q, clk_rst_pwr_pkg::PWR_DEEP)
      step(1);
      `CHK(power_mode_q, clk_rst_pwr_pkg::PWR_WAKING)
      wait_mode(clk_rst_pwr_pkg::PWR_ACTIVE, 800);
      `CHK(power_mode_q, clk_rst_pwr_pkg::PWR_ACTIVE)
      // debug lock, unlock, permanent block
      debug_disable = 1'b1;
      step(1);
      debug_disable = 1'b0;
      fw_debug_enable = 1'b1;
      step(3);
      `CHK(debug_port_en_q, 1'b0)
      {device_erased, protection_cleared} = 2'h3;
      step(3);
      `CHK(debug_port_en_q, 1'b1)
      max_security = 1'b1;
      step(2);
      max_security = 1'b0;
      step(3);
      `CHK({debug_port_en_q, prog_port_en_q, test_port_en_q}, 3'h0)
      complete_run();
   end
endmodule
